// ---- cdio_top.sv ----
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - A line pick register chooses one of four lines for per-line access.
// - Each line is set as input or output by a direction bit.
// - Capable lines can switch the auxiliary 3.3V rail onto the pin.
// - A per-line polarity flag inverts the line, input or output.
// - Read-only level shows the present state of the picked line.
// - Level vector shows all lines, line n at bit n.
// - Per line, software picks glitch or bounce as the width target.
// - A separate microsecond width is held per line and filter kind.
// - Glitch rejection runs first and feeds bounce suppression.
// - Bounce filter takes the first edge, then ignores changes for its width.
// - Per line output source pick, used only when the line is output.
// - Sources: loopback, soft outputs, counter, logic, exposure, trigger wait.
// - Read-only electrical kind per line: tri-state, opto or open drain.
// - Exposure report mode picks line-based, any pixels or all pixels.
// - A soft output pick chooses one of four soft output bits.
// - Soft output level writes and reads back the picked bit.
// - Soft output vector holds soft output n at bit n.
// - Vector write updates all soft outputs at once; read returns all.
module cdio_top #(
    parameter int N_LINES = cdio_pkg::N_LINES,
    parameter logic [2*cdio_pkg::N_LINES-1:0] LINE_KINDS = cdio_pkg::DEF_LINE_KINDS,
    parameter logic [cdio_pkg::N_LINES-1:0] AUX_CAPABLE = cdio_pkg::DEF_AUX_CAPABLE
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [cdio_pkg::ADDR_W-1:0] i_addr,
    input wire logic [cdio_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [cdio_pkg::DATA_W-1:0] o_rdata,
    input wire logic [cdio_pkg::N_LINES-1:0] i_line_in,
    output logic [cdio_pkg::N_LINES-1:0] o_line_out,
    output logic [cdio_pkg::N_LINES-1:0] o_line_oe,
    output logic [cdio_pkg::N_LINES-1:0] o_aux_rail,
    input wire logic i_counter_active,
    input wire logic [cdio_pkg::N_LINES-1:0] i_logic_block,
    input wire logic i_exposure_line,
    input wire logic i_any_pixel_exposing,
    input wire logic i_all_pixel_exposing,
    input wire logic i_frame_trigger_wait
);

    localparam int NL = cdio_pkg::N_LINES;
    localparam int NS = cdio_pkg::N_SOFT;
    localparam int PICK_W = $clog2(NL);
    localparam int SPICK_W = $clog2(NS);
    localparam int FW = cdio_pkg::FILT_W;
    localparam int CW = cdio_pkg::CNT_W;

    // Register map and vectors are fixed at four lines
    if (N_LINES != NL) begin : g_bad_lines
        $error("cdio_top supports exactly four lines");
    end

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] k);
        return a == k;
    endfunction

    wire logic wr_pick = i_wr && hit(i_addr, cdio_pkg::A_LINE_PICK);
    wire logic wr_dir = i_wr && hit(i_addr, cdio_pkg::A_LINE_DIRECTION);
    wire logic wr_rail = i_wr && hit(i_addr, cdio_pkg::A_AUX_RAIL_ENABLE);
    wire logic wr_flip = i_wr && hit(i_addr, cdio_pkg::A_POLARITY_FLIP);
    wire logic wr_fkind = i_wr && hit(i_addr, cdio_pkg::A_INPUT_FILTER_KIND);
    wire logic wr_width = i_wr && hit(i_addr, cdio_pkg::A_FILTER_WINDOW_US);
    wire logic wr_osrc = i_wr && hit(i_addr, cdio_pkg::A_OUTPUT_SIGNAL_PICK);
    wire logic wr_emode = i_wr && hit(i_addr, cdio_pkg::A_EXPOSURE_REPORT_MODE);
    wire logic wr_spick = i_wr && hit(i_addr, cdio_pkg::A_SOFT_OUTPUT_PICK);
    wire logic wr_slevel = i_wr && hit(i_addr, cdio_pkg::A_SOFT_OUTPUT_LEVEL);
    wire logic wr_svec = i_wr && hit(i_addr, cdio_pkg::A_SOFT_OUTPUT_VECTOR);

    // ----------------------------------------
    // Configuration state
    // ----------------------------------------
    logic [PICK_W-1:0] line_pick;
    logic [NL-1:0] line_direction;
    logic [NL-1:0] aux_rail_enable;
    logic [NL-1:0] line_polarity_flip;
    logic [NL-1:0] input_filter_kind;
    logic [FW-1:0] filter_window_us [NL][2];
    cdio_pkg::cdio_osrc_e output_signal_pick [NL];
    cdio_pkg::cdio_exp_e exposure_report_mode;
    logic [SPICK_W-1:0] soft_output_pick;
    logic [NS-1:0] soft_output_vector;
    logic [NL-1:0] drv;
    logic [NL-1:0] line_level_vector;
    logic [NL-1:0] filt_level;
    logic [cdio_pkg::DATA_W-1:0] next_rdata;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            line_pick <= '0;
            exposure_report_mode <= cdio_pkg::EXP_LINE;
            soft_output_pick <= '0;
        end else begin
            if (wr_pick) line_pick <= i_wdata[PICK_W-1:0];
            if (wr_emode) exposure_report_mode <= cdio_pkg::cdio_exp_e'(i_wdata[1:0]);
            if (wr_spick) soft_output_pick <= i_wdata[SPICK_W-1:0];
        end
    end

    // Vector write wins over a single-bit write; both cannot come together anyway
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            soft_output_vector <= cdio_pkg::RST_SOFT;
        end else if (wr_svec) begin
            soft_output_vector <= i_wdata[NS-1:0];
        end else if (wr_slevel) begin
            soft_output_vector[soft_output_pick] <= i_wdata[0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            line_direction <= {NL{cdio_pkg::DIR_IN}};
            aux_rail_enable <= '0;
            line_polarity_flip <= '0;
            input_filter_kind <= {NL{cdio_pkg::FK_GLITCH}};
        end else begin
            if (wr_dir) line_direction[line_pick] <= i_wdata[0];
            // Rail bit sticks at zero on lines without the rail switch
            if (wr_rail) aux_rail_enable[line_pick] <= i_wdata[0] & AUX_CAPABLE[line_pick];
            if (wr_flip) line_polarity_flip[line_pick] <= i_wdata[0];
            if (wr_fkind) input_filter_kind[line_pick] <= i_wdata[0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            for (int n = 0; n < NL; n++) begin
                filter_window_us[n][0] <= cdio_pkg::RST_WINDOW;
                filter_window_us[n][1] <= cdio_pkg::RST_WINDOW;
                output_signal_pick[n] <= cdio_pkg::OSRC_OFF;
            end
        end else begin
            if (wr_width) filter_window_us[line_pick][input_filter_kind[line_pick]] <= i_wdata;
            if (wr_osrc) output_signal_pick[line_pick] <= cdio_pkg::cdio_osrc_e'(i_wdata[2:0]);
        end
    end

    // ----------------------------------------
    // Exposure indication
    // ----------------------------------------
    wire logic exposure_active =
        (exposure_report_mode == cdio_pkg::EXP_ANY) ? i_any_pixel_exposing :
        (exposure_report_mode == cdio_pkg::EXP_ALL) ? i_all_pixel_exposing :
        i_exposure_line;

    // ----------------------------------------
    // Per-line datapath
    // ----------------------------------------
    for (genvar n = 0; n < NL; n++) begin : g_line
        localparam cdio_pkg::cdio_ekind_e KIND = cdio_pkg::cdio_ekind_e'(LINE_KINDS[2*n +: 2]);
        cdio_filt_if #(.CNT_W(CW)) fif ();
        logic [7:0] src_vec;
        logic src_val;
        logic out_val;
        logic next_oe;
        logic next_out;

        assign fif.sample = i_line_in[n];
        // Cycle counts cover the widest window, so the cast cannot clip
        assign fif.glitch_cycles = CW'(filter_window_us[n][0] * cdio_pkg::CYC_PER_US);
        assign fif.bounce_cycles = CW'(filter_window_us[n][1] * cdio_pkg::CYC_PER_US);
        assign filt_level[n] = fif.level;

        cdio_line_filter #(.CNT_W(CW)) u_filt (
            .i_clk(i_clk),
            .i_srst(i_srst),
            .f(fif)
        );

        // Loopback takes the neighbour's level, which comes from flops, so no loop forms
        assign src_vec = {1'b0, i_frame_trigger_wait, exposure_active, i_logic_block[n],
                          i_counter_active, soft_output_vector[n % NS],
                          line_level_vector[(n + 1) % NL], 1'b0};
        assign src_val = src_vec[output_signal_pick[n]];
        assign out_val = src_val ^ line_polarity_flip[n];
        assign next_oe = (line_direction[n] == cdio_pkg::DIR_OUT) &&
                         ((KIND == cdio_pkg::EK_OPTO) ||
                          ((KIND == cdio_pkg::EK_OD) && !out_val));
        assign next_out = (KIND == cdio_pkg::EK_OPTO) ? out_val : 1'b0;

        always_ff @(posedge i_clk) begin
            if (i_srst) begin
                drv[n] <= 1'b0;
                o_line_oe[n] <= 1'b0;
                o_line_out[n] <= 1'b0;
                o_aux_rail[n] <= 1'b0;
            end else begin
                drv[n] <= out_val;
                o_line_oe[n] <= next_oe;
                o_line_out[n] <= next_out;
                o_aux_rail[n] <= aux_rail_enable[n];
            end
        end

        assign line_level_vector[n] = (line_direction[n] == cdio_pkg::DIR_OUT) ? drv[n] :
                                      (filt_level[n] ^ line_polarity_flip[n]);
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    wire logic [1:0] picked_kind = LINE_KINDS[2*line_pick +: 2];

    always_comb begin
        next_rdata = '0;
        case (i_addr)
            cdio_pkg::A_LINE_PICK: next_rdata[PICK_W-1:0] = line_pick;
            cdio_pkg::A_LINE_DIRECTION: next_rdata[0] = line_direction[line_pick];
            cdio_pkg::A_AUX_RAIL_ENABLE: next_rdata[0] = aux_rail_enable[line_pick];
            cdio_pkg::A_POLARITY_FLIP: next_rdata[0] = line_polarity_flip[line_pick];
            cdio_pkg::A_LINE_LEVEL: next_rdata[0] = line_level_vector[line_pick];
            cdio_pkg::A_LINE_LEVEL_VECTOR: next_rdata[NL-1:0] = line_level_vector;
            cdio_pkg::A_INPUT_FILTER_KIND: next_rdata[0] = input_filter_kind[line_pick];
            cdio_pkg::A_FILTER_WINDOW_US:
                next_rdata = filter_window_us[line_pick][input_filter_kind[line_pick]];
            cdio_pkg::A_OUTPUT_SIGNAL_PICK: next_rdata[2:0] = output_signal_pick[line_pick];
            cdio_pkg::A_LINE_ELECTRICAL_KIND: next_rdata[1:0] = picked_kind;
            cdio_pkg::A_EXPOSURE_REPORT_MODE: next_rdata[1:0] = exposure_report_mode;
            cdio_pkg::A_SOFT_OUTPUT_PICK: next_rdata[SPICK_W-1:0] = soft_output_pick;
            cdio_pkg::A_SOFT_OUTPUT_LEVEL: next_rdata[0] = soft_output_vector[soft_output_pick];
            cdio_pkg::A_SOFT_OUTPUT_VECTOR: next_rdata[NS-1:0] = soft_output_vector;
            default: next_rdata = '0;
        endcase
    end

    // Data stands for one cycle only, zero otherwise
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= i_rd ? next_rdata : '0;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    a_pick_steers_flip: assert property (wr_flip
        |=> line_polarity_flip[$past(line_pick)] == $past(i_wdata[0]))
        else $error("Flip write missed the picked line");
    a_input_never_driven: assert property (((~$past(line_direction)) & o_line_oe) == '0)
        else $error("Input line has its driver enabled");
    a_rail_only_capable: assert property ((o_aux_rail & ~AUX_CAPABLE) == '0)
        else $error("Rail switched on an incapable line");
    a_flip_inverts_input: assert property ((line_direction[0] == cdio_pkg::DIR_IN)
        |-> line_level_vector[0] == (filt_level[0] ^ line_polarity_flip[0]))
        else $error("Input level ignores polarity");
    a_level_vector_read: assert property ((i_rd && i_addr == cdio_pkg::A_LINE_LEVEL_VECTOR)
        |=> o_rdata == {{(cdio_pkg::DATA_W-NL){1'b0}}, $past(line_level_vector)})
        else $error("Level vector read wrong");
    a_width_stored: assert property (wr_width
        |=> filter_window_us[$past(line_pick)][$past(input_filter_kind[line_pick])]
            == $past(i_wdata))
        else $error("Filter width not stored");
    a_soft_drives_line: assert property ((output_signal_pick[0] == cdio_pkg::OSRC_SOFT)
        && !line_polarity_flip[0] && $stable(output_signal_pick[0])
        |=> drv[0] == $past(soft_output_vector[0]))
        else $error("Soft output not driven on line");
    a_kind_read: assert property ((i_rd && i_addr == cdio_pkg::A_LINE_ELECTRICAL_KIND)
        |=> o_rdata[1:0] == $past(picked_kind))
        else $error("Electrical kind read wrong");
    a_soft_level_write: assert property (wr_slevel
        |=> soft_output_vector[$past(soft_output_pick)] == $past(i_wdata[0]))
        else $error("Soft level write lost");
    a_soft_vector_write: assert property (wr_svec
        |=> soft_output_vector == $past(i_wdata[NS-1:0]) ##1 1'b1)
        else $error("Soft vector write not simultaneous");
    a_read_one_cycle: assert property (!i_rd |=> o_rdata == '0)
        else $error("Read data outside its cycle");

    c_line_output: cover property (o_line_oe[0] && line_direction[0]);
    c_vector_write: cover property (wr_svec ##1 wr_slevel);
    c_exposure_any: cover property (exposure_report_mode == cdio_pkg::EXP_ANY && exposure_active);

endmodule // cdio_top

`default_nettype wire

// ---- cdio_pkg.sv ----
package cdio_pkg;

    // ----------------------------------------
    // Sizes and timing
    // ----------------------------------------
    localparam int N_LINES = 4;
    localparam int N_SOFT = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int FILT_W = 16;
    localparam int CLK_HZ = 20_000_000;
    localparam int US_PER_S = 1_000_000;
    localparam int CYC_PER_US = CLK_HZ / US_PER_S;
    localparam int CNT_W = FILT_W + $clog2(CYC_PER_US + 1);

    // ----------------------------------------
    // Register addresses (word index)
    // ----------------------------------------
    localparam logic [7:0] A_LINE_PICK = 8'h00;
    localparam logic [7:0] A_LINE_DIRECTION = 8'h01;
    localparam logic [7:0] A_AUX_RAIL_ENABLE = 8'h02;
    localparam logic [7:0] A_POLARITY_FLIP = 8'h03;
    localparam logic [7:0] A_LINE_LEVEL = 8'h04;
    localparam logic [7:0] A_LINE_LEVEL_VECTOR = 8'h05;
    localparam logic [7:0] A_INPUT_FILTER_KIND = 8'h06;
    localparam logic [7:0] A_FILTER_WINDOW_US = 8'h07;
    localparam logic [7:0] A_OUTPUT_SIGNAL_PICK = 8'h08;
    localparam logic [7:0] A_LINE_ELECTRICAL_KIND = 8'h09;
    localparam logic [7:0] A_EXPOSURE_REPORT_MODE = 8'h0a;
    localparam logic [7:0] A_SOFT_OUTPUT_PICK = 8'h0b;
    localparam logic [7:0] A_SOFT_OUTPUT_LEVEL = 8'h0c;
    localparam logic [7:0] A_SOFT_OUTPUT_VECTOR = 8'h0d;

    // ----------------------------------------
    // Encodings and reset values
    // ----------------------------------------
    localparam logic DIR_IN = 1'b0;
    localparam logic DIR_OUT = 1'b1;
    localparam logic FK_GLITCH = 1'b0;
    localparam logic FK_BOUNCE = 1'b1;
    localparam logic [FILT_W-1:0] RST_WINDOW = 16'h0000;
    localparam logic [N_SOFT-1:0] RST_SOFT = 4'h0;
    // Per line two bits: line0 opto, line1 open drain, line2 tri-state, line3 open drain
    localparam logic [2*N_LINES-1:0] DEF_LINE_KINDS = 8'h89;
    localparam logic [N_LINES-1:0] DEF_AUX_CAPABLE = 4'h4;

    typedef enum logic [2:0] {
        OSRC_OFF,
        OSRC_LOOPBACK,
        OSRC_SOFT,
        OSRC_COUNTER,
        OSRC_LOGIC,
        OSRC_EXPOSURE,
        OSRC_TRIG_WAIT
    } cdio_osrc_e;

    typedef enum logic [1:0] {
        EXP_LINE,
        EXP_ANY,
        EXP_ALL
    } cdio_exp_e;

    typedef enum logic [1:0] {
        EK_TRI,
        EK_OPTO,
        EK_OD
    } cdio_ekind_e;

endpackage

// ---- cdio_filt_if.sv ----
`timescale 1ns/10ps
`default_nettype none

interface cdio_filt_if #(
    parameter int CNT_W = 21
) ();
    logic sample;
    logic [CNT_W-1:0] glitch_cycles;
    logic [CNT_W-1:0] bounce_cycles;
    logic level;

    modport ctl (output sample, output glitch_cycles, output bounce_cycles, input level);
    modport filt (input sample, input glitch_cycles, input bounce_cycles, output level);
endinterface

`default_nettype wire

// ---- cdio_line_filter.sv ----
`timescale 1ns/10ps
`default_nettype none

module cdio_line_filter #(
    parameter int CNT_W = 21
) (
    input wire logic i_clk,
    input wire logic i_srst,
    cdio_filt_if.filt f
);

    // ----------------------------------------
    // Synchroniser
    // ----------------------------------------
    logic s1;
    logic s2;
    logic s3;
    logic stable;
    logic g_level;
    logic [CNT_W-1:0] g_cnt;
    logic b_level;
    logic [CNT_W-1:0] b_cnt;
    wire logic agree = (s2 == s3);
    wire logic [CNT_W-1:0] g_cnt_inc = g_cnt + 1'b1;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            stable <= 1'b0;
        end else begin
            s1 <= f.sample;
            s2 <= s1;
            s3 <= s2;
            stable <= agree ? s3 : stable;
        end
    end

    // ----------------------------------------
    // Glitch rejection, then bounce suppression
    // ----------------------------------------
    // Zero width passes the level straight through
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            g_level <= 1'b0;
            g_cnt <= '0;
        end else if (stable == g_level) begin
            g_cnt <= '0;
        end else if (g_cnt_inc >= f.glitch_cycles) begin
            g_level <= stable;
            g_cnt <= '0;
        end else begin
            g_cnt <= g_cnt_inc;
        end
    end

    // First edge passes at once, later edges wait out the hold
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            b_level <= 1'b0;
            b_cnt <= '0;
        end else if (b_cnt != '0) begin
            b_cnt <= b_cnt - 1'b1;
        end else if (g_level != b_level) begin
            b_level <= g_level;
            b_cnt <= f.bounce_cycles;
        end
    end

    assign f.level = b_level;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    a_bounce_hold_stable: assert property (b_cnt != '0 |=> $stable(b_level))
        else $error("Filtered level moved during bounce hold");
    a_bounce_first_edge: assert property ((b_cnt == '0 && g_level != b_level)
        |=> (b_level == $past(g_level)) && (b_cnt == $past(f.bounce_cycles)))
        else $error("First edge not taken at once");
    a_glitch_feeds_bounce: assert property ($changed(b_level) |-> b_level == $past(g_level))
        else $error("Bounce stage not fed by glitch stage");
    a_glitch_width_met: assert property ($changed(g_level)
        |-> $past(g_cnt_inc) >= $past(f.glitch_cycles))
        else $error("Glitch stage moved before its width");
    a_sync_two_agree: assert property ($changed(stable) |-> $past(agree))
        else $error("Synchroniser moved without agreement");

    c_bounce_hold: cover property (b_cnt != '0 && g_level != b_level);

endmodule // cdio_line_filter

`default_nettype wire

// ---- cdio_ext_circuit.sv ----
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// External circuits on the connector
// ----------------------------------------
module cdio_ext_circuit (
    input wire logic [3:0] i_line_out,
    input wire logic [3:0] i_line_oe,
    input wire logic [3:0] i_drive,
    input wire logic [3:0] i_drive_en,
    output logic [3:0] o_pin
);
    // Pull-up on every pin, since open drain lines cannot drive high
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            o_pin[n] = i_line_oe[n] ? i_line_out[n] : (i_drive_en[n] ? i_drive[n] : 1'b1);
        end
    end
endmodule // cdio_ext_circuit

`default_nettype wire

// ---- camera_digital_io_lines_bench.sv ----
`timescale 1ns/10ps
`default_nettype none

module camera_digital_io_lines_bench;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [15:0] o_rdata;
    logic [3:0] pin, o_line_out, o_line_oe, o_aux_rail;
    logic [3:0] drv = 4'h0, drv_en = 4'h0, lb = 4'h0;
    logic cnt = 1'b0, expl = 1'b0, anyp = 1'b0, allp = 1'b0, trig = 1'b0;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;

    cdio_top DUT (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_line_in(pin),
        .o_line_out(o_line_out), .o_line_oe(o_line_oe), .o_aux_rail(o_aux_rail),
        .i_counter_active(cnt), .i_logic_block(lb), .i_exposure_line(expl),
        .i_any_pixel_exposing(anyp), .i_all_pixel_exposing(allp), .i_frame_trigger_wait(trig));
    cdio_ext_circuit ext (.i_line_out(o_line_out), .i_line_oe(o_line_oe), .i_drive(drv),
        .i_drive_en(drv_en), .o_pin(pin));

    always #25 i_clk = ~i_clk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic final_report();
        if (failures == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Run is about 400 cycles; this ceiling only catches a hang
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // Release lands on the edge and the task returns 1 ns later, so no strobe is set twice in one step
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(nm, exp, o_rdata);
    endtask
    task automatic src(input logic [2:0] code, input logic [1:0] mode, input logic exp);
        wr(8'h0a, {14'h0, mode});
        wr(8'h08, {13'h0, code});
        idle(2);
        chk("line0 source", {15'h0, exp}, {15'h0, o_line_out[0]});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk("outputs at reset", 16'h0000, {4'h0, o_line_out, o_line_oe, o_aux_rail});
        rd(8'h00, 16'h0000, "line pick");
        rd(8'h0a, 16'h0000, "exposure mode");
        for (int n = 0; n < 4; n++) begin
            wr(8'h00, 16'(n));
            rd(8'h09, {14'h0, cdio_pkg::DEF_LINE_KINDS[2*n +: 2]}, "electrical kind");
        end
        rd(8'h3f, 16'h0000, "unmapped read");
    endtask

    task automatic t_soft();
        wr(8'h0d, 16'h000a);
        rd(8'h0d, 16'h000a, "soft vector");
        for (int n = 0; n < 4; n++) begin
            wr(8'h0b, 16'(n));
            rd(8'h0c, {15'h0, n[0]}, "soft level");
        end
        wr(8'h0b, 16'h0000);
        wr(8'h0c, 16'h0001);
        rd(8'h0d, 16'h000b, "soft vector after level");
        wr(8'h0d, 16'h0005);
        rd(8'h0c, 16'h0001, "soft level after vector");
    endtask

    task automatic t_drive();
        wr(8'h00, 16'h0000);
        wr(8'h08, 16'h0002);
        idle(2);
        chk("oe while input", 16'h0, {15'h0, o_line_oe[0]});
        wr(8'h01, 16'h0001);
        idle(2);
        chk("line0 oe out", 16'h3, {14'h0, o_line_oe[0], o_line_out[0]});
        rd(8'h04, 16'h0001, "line0 level");
        rd(8'h05, 16'h000f, "level vector");
        wr(8'h03, 16'h0001);
        idle(2);
        chk("flipped out", 16'h0, {15'h0, o_line_out[0]});
        rd(8'h05, 16'h000e, "level vector flipped");
        wr(8'h03, 16'h0000);
    endtask

    task automatic t_sources();
        for (int p = 0; p < 2; p++) begin
            cnt <= p[0];
            lb <= p[0] ? 4'h1 : 4'he;
            expl <= p[0];
            anyp <= p[0];
            allp <= !p[0];
            trig <= p[0];
            drv_en <= 4'h2;
            drv <= {2'h0, p[0], 1'b0};
            idle(12);
            src(3'h1, 2'h0, p[0]);
            src(3'h3, 2'h0, p[0]);
            src(3'h4, 2'h0, p[0]);
            src(3'h5, 2'h0, p[0]);
            src(3'h5, 2'h1, p[0]);
            src(3'h5, 2'h2, !p[0]);
            src(3'h6, 2'h0, p[0]);
            src(3'h0, 2'h0, 1'b0);
        end
        drv_en <= 4'h0;
    endtask

    task automatic t_kinds();
        wr(8'h00, 16'h0001);
        wr(8'h01, 16'h0001);
        wr(8'h08, 16'h0002);
        idle(2);
        chk("open drain low", 16'h2, {14'h0, o_line_oe[1], o_line_out[1]});
        wr(8'h0d, 16'h0007);
        idle(2);
        chk("open drain high", 16'h0, {15'h0, o_line_oe[1]});
        rd(8'h04, 16'h0001, "line1 level");
        wr(8'h00, 16'h0002);
        wr(8'h01, 16'h0001);
        wr(8'h08, 16'h0002);
        wr(8'h02, 16'h0001);
        idle(2);
        chk("tri-state and rail", 16'h4, {o_line_oe[2], o_aux_rail});
        wr(8'h00, 16'h0000);
        wr(8'h02, 16'h0001);
        rd(8'h02, 16'h0000, "rail incapable");
    endtask

    task automatic t_filter();
        wr(8'h00, 16'h0003);
        drv_en <= 4'h8;
        drv <= 4'h0;
        wr(8'h07, 16'h0001);
        wr(8'h06, 16'h0001);
        wr(8'h07, 16'h0002);
        wr(8'h06, 16'h0000);
        rd(8'h07, 16'h0001, "glitch width");
        idle(40);
        drv <= 4'h8;
        idle(10);
        drv <= 4'h0;
        idle(30);
        rd(8'h04, 16'h0000, "short pulse");
        drv <= 4'h8;
        idle(40);
        rd(8'h04, 16'h0001, "long pulse");
        wr(8'h07, 16'h0000);
        idle(50);
        drv <= 4'h0;
        idle(10);
        rd(8'h04, 16'h0000, "bounce first edge");
        drv <= 4'h8;
        idle(10);
        rd(8'h04, 16'h0000, "bounce hold");
        idle(40);
        rd(8'h04, 16'h0001, "bounce released");
        wr(8'h03, 16'h0001);
        rd(8'h04, 16'h0000, "input flipped");
    endtask

    initial begin
        repeat (10) @(posedge i_clk);
        i_srst <= 1'b0;
        #1;
        t_reset();
        t_soft();
        t_drive();
        t_sources();
        t_kinds();
        t_filter();
        final_report();
    end
endmodule // camera_digital_io_lines_bench

`default_nettype wire
